// ---- design/chfic_top.sv ----
// card host flow control, interrupt aggregation and control registers
//
// What this block does
// - flow control gates card clock, both directions
// - transmit: stop clock when both FIFOs empty
// - transmit: restart when either empty flag clears
// - receive: stop clock when both FIFOs full
// - receive: restart when either full flag clears
// - stopped clock freezes all card lines
// - eight interrupt source flags exist
// - each flag has its own mask bit
// - unmasked flag with global enable raises request
// - flag register read returns then clears flags
// - format bit 6 holds data write pointer reset
// - format bit 5 holds command receive pointer reset
// - format bit 4 holds command transmit pointer reset
// - format bit 2 selects block or stream
// - format bit 1 selects 48 or 136 response
// - transfer bit 3 selects data direction
// - pulse on transfer bit 1 arms response
// - transfer register resets to zero
// - FIFO empty and full flags follow FIFOs
//
// Implementation choice: the APB register port.
`timescale 1ns/1ps
module chfic_top
  import chfic_pkg::*;
#(
  parameter int CARD_HALF_DIV = CHFIC_CARD_HALF_DIV
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [CHFIC_ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic fifo_one_empty_i,
  input wire logic fifo_two_empty_i,
  input wire logic fifo_one_full_i,
  input wire logic fifo_two_full_i,
  input wire logic card_busy_change_i,
  input wire logic end_of_response_i,
  input wire logic end_of_command_i,
  input wire logic end_of_frame_i,
  input wire logic [7:0] card_data_rd_i,
  output logic [7:0] card_data_wr_o,
  output logic card_data_push_o,
  output logic card_data_pop_o,
  output logic card_clock_o,
  output logic card_tick_o,
  output logic card_frozen_o,
  output logic data_read_pointer_reset_o,
  output logic data_write_pointer_reset_o,
  output logic cmd_rx_pointer_reset_o,
  output logic cmd_tx_pointer_reset_o,
  output logic multi_block_select_o,
  output logic data_format_select_o,
  output logic response_length_select_o,
  output logic crc7_disable_o,
  output logic [3:0] block_length_code_o,
  output logic data_direction_o,
  output logic data_transfer_start_o,
  output logic response_receive_start_o,
  output logic command_send_start_o,
  output logic irq_o
);

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic [7:0] ctl_format_q;
  logic [7:0] ctl_transfer_q;
  logic [7:0] ctl_timing_q;
  logic [7:0] irq_flags_q;
  logic [7:0] irq_masks_q;
  logic cpu_ien_q;
  logic [9:0] reg_idx;
  logic addr_ok;
  logic setup_ph;
  logic access_ph;
  logic wr_acc;
  logic rd_acc;
  logic [7:0] rd_mux;
  logic wr_lane0;

  assign reg_idx = paddr_i[CHFIC_ADDR_W-1:2];
  assign setup_ph = psel_i && !penable_i;
  assign access_ph = psel_i && penable_i;
  assign wr_lane0 = pstrb_i[0];
  assign wr_acc = access_ph && pwrite_i && addr_ok && wr_lane0;
  assign rd_acc = access_ph && !pwrite_i && addr_ok;
  assign pready_o = access_ph;

  always_comb begin
    addr_ok = (paddr_i[1:0] == 2'h0);
    rd_mux = 8'h00;
    unique case (reg_idx)
      CHFIC_IDX_CTL_FORMAT: rd_mux = ctl_format_q;
      CHFIC_IDX_CTL_TRANSFER: rd_mux = ctl_transfer_q;
      CHFIC_IDX_CTL_TIMING: rd_mux = ctl_timing_q;
      CHFIC_IDX_IRQ_FLAGS: rd_mux = irq_flags_q;
      CHFIC_IDX_IRQ_MASKS: rd_mux = irq_masks_q;
      CHFIC_IDX_CPU_IEN: rd_mux = {7'h00, cpu_ien_q};
      CHFIC_IDX_DATA_PORT: rd_mux = card_data_rd_i;
      default: addr_ok = 1'b0;
    endcase
  end

  // read data captured in setup; flag register keeps its pre-clear value
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      prdata_o <= 32'h0000_0000;
    end else if (setup_ph) begin
      prdata_o <= (!pwrite_i && addr_ok) ? {24'h00_0000, rd_mux} : 32'h0000_0000;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pslverr_o <= 1'b0;
    end else if (setup_ph) begin
      pslverr_o <= !addr_ok;
    end
  end

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctl_format_q <= CHFIC_RST_CTL_FORMAT;
    end else if (wr_acc && reg_idx == CHFIC_IDX_CTL_FORMAT) begin
      ctl_format_q <= pwdata_i[7:0];
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctl_transfer_q <= CHFIC_RST_CTL_TRANSFER;
    end else if (wr_acc && reg_idx == CHFIC_IDX_CTL_TRANSFER) begin
      ctl_transfer_q <= pwdata_i[7:0];
    end
  end

  // reserved bits 4..3 of the timing register read as zero
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctl_timing_q <= CHFIC_RST_CTL_TIMING;
    end else if (wr_acc && reg_idx == CHFIC_IDX_CTL_TIMING) begin
      ctl_timing_q <= pwdata_i[7:0] & 8'hE7;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_masks_q <= CHFIC_RST_IRQ_MASKS;
    end else if (wr_acc && reg_idx == CHFIC_IDX_IRQ_MASKS) begin
      irq_masks_q <= pwdata_i[7:0];
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cpu_ien_q <= 1'b0;
    end else if (wr_acc && reg_idx == CHFIC_IDX_CPU_IEN) begin
      cpu_ien_q <= pwdata_i[CHFIC_CPU_IEN_BIT];
    end
  end

  assign data_read_pointer_reset_o = ctl_format_q[CHFIC_B_DATA_RD_PTR_RST];
  assign data_write_pointer_reset_o = ctl_format_q[CHFIC_B_DATA_WR_PTR_RST];
  assign cmd_rx_pointer_reset_o = ctl_format_q[CHFIC_B_CMD_RX_PTR_RST];
  assign cmd_tx_pointer_reset_o = ctl_format_q[CHFIC_B_CMD_TX_PTR_RST];
  assign multi_block_select_o = ctl_format_q[CHFIC_B_MULTI_BLOCK];
  assign data_format_select_o = ctl_format_q[CHFIC_B_DATA_FORMAT];
  assign response_length_select_o = ctl_format_q[CHFIC_B_RESP_LENGTH];
  assign crc7_disable_o = ctl_format_q[CHFIC_B_CRC7_DISABLE];
  assign block_length_code_o = ctl_transfer_q[CHFIC_B_BLEN_HI:CHFIC_B_BLEN_LO];
  assign data_direction_o = ctl_transfer_q[CHFIC_B_DATA_DIR];

  // ----------------------------------------------------------------
  // set-then-clear triggers
  // ----------------------------------------------------------------
  logic [2:0] trig_prev_q;
  logic [2:0] trig_now;
  logic [2:0] trig_pulse_q;

  assign trig_now = ctl_transfer_q[CHFIC_B_DATA_TRIG:CHFIC_B_CMD_TRIG];

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      trig_prev_q <= 3'h0;
      trig_pulse_q <= 3'h0;
    end else begin
      trig_prev_q <= trig_now;
      trig_pulse_q <= trig_prev_q & ~trig_now;
    end
  end

  assign data_transfer_start_o = trig_pulse_q[2];
  assign response_receive_start_o = trig_pulse_q[1];
  assign command_send_start_o = trig_pulse_q[0];

  // ----------------------------------------------------------------
  // data port
  // ----------------------------------------------------------------
  logic data_hit;

  assign data_hit = access_ph && addr_ok && reg_idx == CHFIC_IDX_DATA_PORT;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      card_data_push_o <= 1'b0;
      card_data_pop_o <= 1'b0;
      card_data_wr_o <= 8'h00;
    end else begin
      card_data_push_o <= data_hit && pwrite_i && wr_lane0;
      card_data_pop_o <= data_hit && !pwrite_i;
      if (data_hit && pwrite_i && wr_lane0) begin
        card_data_wr_o <= pwdata_i[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // flow control
  // ----------------------------------------------------------------
  logic flow_en;
  logic stop_cond;
  logic restart_cond;
  logic stopped_q;

  assign flow_en = ctl_timing_q[CHFIC_B_FLOW_CTRL];

  always_comb begin
    if (data_direction_o) begin
      stop_cond = fifo_one_empty_i && fifo_two_empty_i;
      restart_cond = !fifo_one_empty_i || !fifo_two_empty_i;
    end else begin
      stop_cond = fifo_one_full_i && fifo_two_full_i;
      restart_cond = !fifo_one_full_i || !fifo_two_full_i;
    end
  end

  // stopped state only exists while flow control is on
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      stopped_q <= 1'b0;
    end else if (!flow_en) begin
      stopped_q <= 1'b0;
    end else if (!stopped_q && stop_cond) begin
      stopped_q <= 1'b1;
    end else if (stopped_q && restart_cond) begin
      stopped_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // card clock divider
  // ----------------------------------------------------------------
  logic [15:0] div_cnt_q;
  logic clk_run;
  logic div_wrap;

  assign clk_run = ctl_timing_q[CHFIC_B_CLOCK_ENABLE] && !stopped_q;
  assign div_wrap = (div_cnt_q == 16'(CARD_HALF_DIV - 1));
  assign card_frozen_o = !clk_run;

  // counter and clock hold their state while stopped so lines stay frozen
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      div_cnt_q <= 16'h0000;
      card_clock_o <= 1'b0;
      card_tick_o <= 1'b0;
    end else begin
      card_tick_o <= 1'b0;
      if (clk_run) begin
        if (div_wrap) begin
          div_cnt_q <= 16'h0000;
          card_clock_o <= !card_clock_o;
          card_tick_o <= !card_clock_o;
        end else begin
          div_cnt_q <= div_cnt_q + 16'h0001;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // interrupt flags
  // ----------------------------------------------------------------
  logic [7:0] flag_set;
  logic flags_rd;

  always_comb begin
    flag_set = 8'h00;
    flag_set[CHFIC_F_BUSY_CHANGE] = card_busy_change_i;
    flag_set[CHFIC_F_END_RESPONSE] = end_of_response_i;
    flag_set[CHFIC_F_END_COMMAND] = end_of_command_i;
    flag_set[CHFIC_F_END_FRAME] = end_of_frame_i;
    flag_set[CHFIC_F_FIFO_TWO_FULL] = fifo_two_full_i;
    flag_set[CHFIC_F_FIFO_ONE_FULL] = fifo_one_full_i;
    flag_set[CHFIC_F_FIFO_TWO_EMPTY] = fifo_two_empty_i;
    flag_set[CHFIC_F_FIFO_ONE_EMPTY] = fifo_one_empty_i;
  end

  assign flags_rd = rd_acc && reg_idx == CHFIC_IDX_IRQ_FLAGS;

  // a set in the clearing cycle wins
  genvar gi;
  generate
    for (gi = 0; gi < CHFIC_N_FLAGS; gi++) begin : g_flag
      always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
          irq_flags_q[gi] <= CHFIC_RST_FLAGS[gi];
        end else if (flag_set[gi]) begin
          irq_flags_q[gi] <= 1'b1;
        end else if (flags_rd) begin
          irq_flags_q[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  assign irq_o = cpu_ien_q && |(irq_flags_q & ~irq_masks_q);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_tx_stop: assert property (@(posedge clk_i) disable iff (rst_i)
    flow_en && data_direction_o && !stopped_q && fifo_one_empty_i && fifo_two_empty_i
    |=> stopped_q || !flow_en)
    else $error("card clock not stopped with both FIFOs empty");

  chk_tx_restart: assert property (@(posedge clk_i) disable iff (rst_i)
    stopped_q && data_direction_o && !fifo_one_empty_i |=> !stopped_q)
    else $error("card clock not restarted after transmit refill");

  chk_rx_stop: assert property (@(posedge clk_i) disable iff (rst_i)
    flow_en && !data_direction_o && !stopped_q && fifo_one_full_i && fifo_two_full_i
    |=> stopped_q || !flow_en)
    else $error("card clock not stopped with both FIFOs full");

  chk_rx_restart: assert property (@(posedge clk_i) disable iff (rst_i)
    stopped_q && !data_direction_o && !fifo_two_full_i |=> !stopped_q)
    else $error("card clock not restarted after receive drain");

  chk_clock_frozen: assert property (@(posedge clk_i) disable iff (rst_i)
    stopped_q ##1 stopped_q |-> $stable(card_clock_o) && !card_tick_o)
    else $error("card clock moved while stopped");

  chk_flow_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    !flow_en |=> !stopped_q)
    else $error("clock stopped without flow control");

  chk_irq_mask: assert property (@(posedge clk_i) disable iff (rst_i)
    irq_o |-> cpu_ien_q && (irq_flags_q & ~irq_masks_q) != 8'h00)
    else $error("interrupt raised without unmasked flag");

  chk_irq_raise: assert property (@(posedge clk_i) disable iff (rst_i)
    cpu_ien_q && !irq_masks_q[CHFIC_F_END_FRAME] && end_of_frame_i
    ##1 cpu_ien_q && !irq_masks_q[CHFIC_F_END_FRAME] |-> irq_o)
    else $error("unmasked end of frame did not interrupt");

  chk_flag_readback: assert property (@(posedge clk_i) disable iff (rst_i)
    setup_ph && !pwrite_i && addr_ok && reg_idx == CHFIC_IDX_IRQ_FLAGS
    ##1 access_ph |-> prdata_o[7:0] == $past(irq_flags_q))
    else $error("flag read did not return pre-clear value");

  chk_flag_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    flags_rd && flag_set == 8'h00 |=> irq_flags_q == 8'h00)
    else $error("flag read did not clear flags");

  chk_set_wins: assert property (@(posedge clk_i) disable iff (rst_i)
    flags_rd |=> (irq_flags_q & $past(flag_set)) == $past(flag_set))
    else $error("flag set lost during clear");

  chk_cmd_trigger: assert property (@(posedge clk_i) disable iff (rst_i)
    trig_now[0] ##1 !trig_now[0] |=> command_send_start_o ##1 !command_send_start_o)
    else $error("command start pulse missing");

  chk_resp_trigger: assert property (@(posedge clk_i) disable iff (rst_i)
    response_receive_start_o |-> $past(trig_now[1], 2) && !$past(trig_now[1]))
    else $error("response start without set-then-clear");

  chk_ptr_reset: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_acc && reg_idx == CHFIC_IDX_CTL_FORMAT
    |=> data_write_pointer_reset_o == $past(pwdata_i[CHFIC_B_DATA_WR_PTR_RST]))
    else $error("pointer reset output mismatch");

endmodule : chfic_top

// ---- shared/chfic_pkg.sv ----
// constants for the card host flow-control, interrupt and control block
package chfic_pkg;
  // ----------------------------------------------------------------
  // register indices; byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [9:0] CHFIC_IDX_CTL_FORMAT = 10'h0E4;
  localparam logic [9:0] CHFIC_IDX_CTL_TRANSFER = 10'h0E5;
  localparam logic [9:0] CHFIC_IDX_CTL_TIMING = 10'h0E6;
  localparam logic [9:0] CHFIC_IDX_IRQ_FLAGS = 10'h0E7;
  localparam logic [9:0] CHFIC_IDX_IRQ_MASKS = 10'h0E8;
  localparam logic [9:0] CHFIC_IDX_CPU_IEN = 10'h0E9;
  localparam logic [9:0] CHFIC_IDX_DATA_PORT = 10'h0EA;
  localparam int CHFIC_ADDR_W = 12;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] CHFIC_RST_CTL_FORMAT = 8'h00;
  localparam logic [7:0] CHFIC_RST_CTL_TRANSFER = 8'h00;
  localparam logic [7:0] CHFIC_RST_CTL_TIMING = 8'h00;
  localparam logic [7:0] CHFIC_RST_IRQ_MASKS = 8'hFF;
  localparam logic [7:0] CHFIC_RST_FLAGS = 8'h00;

  // ----------------------------------------------------------------
  // control format register fields
  // ----------------------------------------------------------------
  localparam int CHFIC_B_DATA_RD_PTR_RST = 7;
  localparam int CHFIC_B_DATA_WR_PTR_RST = 6;
  localparam int CHFIC_B_CMD_RX_PTR_RST = 5;
  localparam int CHFIC_B_CMD_TX_PTR_RST = 4;
  localparam int CHFIC_B_MULTI_BLOCK = 3;
  localparam int CHFIC_B_DATA_FORMAT = 2;
  localparam int CHFIC_B_RESP_LENGTH = 1;
  localparam int CHFIC_B_CRC7_DISABLE = 0;

  // ----------------------------------------------------------------
  // control transfer register fields
  // ----------------------------------------------------------------
  localparam int CHFIC_B_BLEN_HI = 7;
  localparam int CHFIC_B_BLEN_LO = 4;
  localparam int CHFIC_B_DATA_DIR = 3;
  localparam int CHFIC_B_DATA_TRIG = 2;
  localparam int CHFIC_B_RESP_TRIG = 1;
  localparam int CHFIC_B_CMD_TRIG = 0;

  // ----------------------------------------------------------------
  // control timing register fields
  // ----------------------------------------------------------------
  localparam int CHFIC_B_CLOCK_ENABLE = 7;
  localparam int CHFIC_B_FLOW_CTRL = 0;

  // ----------------------------------------------------------------
  // interrupt flag and mask positions
  // ----------------------------------------------------------------
  localparam int CHFIC_F_BUSY_CHANGE = 7;
  localparam int CHFIC_F_END_RESPONSE = 6;
  localparam int CHFIC_F_END_COMMAND = 5;
  localparam int CHFIC_F_END_FRAME = 4;
  localparam int CHFIC_F_FIFO_TWO_FULL = 3;
  localparam int CHFIC_F_FIFO_ONE_FULL = 2;
  localparam int CHFIC_F_FIFO_TWO_EMPTY = 1;
  localparam int CHFIC_F_FIFO_ONE_EMPTY = 0;
  localparam int CHFIC_N_FLAGS = 8;
  localparam int CHFIC_CPU_IEN_BIT = 0;

  // ----------------------------------------------------------------
  // card clock divider
  // ----------------------------------------------------------------
  localparam int CHFIC_CARD_HALF_DIV = 4;
endpackage : chfic_pkg

// ---- tb/chfic_fifo_model.sv ----
// behavioural pair of 8-byte data fifos on the card side of the block
`timescale 1ns/1ps
module chfic_fifo_model (
  input wire logic clk_i,
  input wire logic push_i,
  input wire logic pop_i,
  input wire logic flush_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  output logic one_empty_o,
  output logic two_empty_o,
  output logic one_full_o,
  output logic two_full_o
);
  logic [7:0] q[$];
  int n;
  initial begin
    rdata_o = 8'hA5;
    {one_empty_o, two_empty_o, one_full_o, two_full_o} = 4'hC;
  end
  // fifo one fills first; an empty head alternates between the last byte and its complement
  always @(posedge clk_i) begin
    if (flush_i) q.delete();
    if (push_i && q.size() < 16) q.push_back(wdata_i);
    if (pop_i && q.size() > 0) void'(q.pop_front());
    n = q.size();
    rdata_o <= (n != 0) ? q[0] : ~rdata_o;
    one_empty_o <= (n == 0);
    two_empty_o <= (n <= 8);
    one_full_o <= (n >= 8);
    two_full_o <= (n == 16);
  end
endmodule : chfic_fifo_model

// ---- tb/test_chfic_top.sv ----
// self-checking bench for the card host flow, interrupt and control block
`timescale 1ns/1ps
module test_chfic_top;
  import chfic_pkg::*;
  localparam int HALF = 2;
  logic clk_i = 0;
  logic rst_i = 1;
  logic psel = 0, pen = 0, pwr = 0;
  logic [CHFIC_ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [3:0] pstrb = 4'hF;
  logic [3:0] ev = '0;
  logic [31:0] prdata;
  logic pready, pslverr, push, pop, cclk, tick, frozen, dir, irq;
  logic f1e, f2e, f1f, f2f;
  logic [7:0] hd, wd, fmt_o;
  logic [3:0] blen;
  logic [2:0] starts;
  int error_cnt = 0;
  int comparisons = 0;
  int scnt[3];
  integer seed = 32'hECAF85F3;
  logic [7:0] expq[$];

  always #2.5 clk_i = ~clk_i;

  chfic_top #(.CARD_HALF_DIV(HALF)) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
    .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .fifo_one_empty_i(f1e),
    .fifo_two_empty_i(f2e), .fifo_one_full_i(f1f), .fifo_two_full_i(f2f),
    .card_busy_change_i(ev[3]), .end_of_response_i(ev[2]), .end_of_command_i(ev[1]),
    .end_of_frame_i(ev[0]), .card_data_rd_i(hd), .card_data_wr_o(wd),
    .card_data_push_o(push), .card_data_pop_o(pop), .card_clock_o(cclk),
    .card_tick_o(tick), .card_frozen_o(frozen), .data_read_pointer_reset_o(fmt_o[7]),
    .data_write_pointer_reset_o(fmt_o[6]), .cmd_rx_pointer_reset_o(fmt_o[5]),
    .cmd_tx_pointer_reset_o(fmt_o[4]), .multi_block_select_o(fmt_o[3]),
    .data_format_select_o(fmt_o[2]), .response_length_select_o(fmt_o[1]),
    .crc7_disable_o(fmt_o[0]), .block_length_code_o(blen), .data_direction_o(dir),
    .data_transfer_start_o(starts[2]), .response_receive_start_o(starts[1]),
    .command_send_start_o(starts[0]), .irq_o(irq));

  chfic_fifo_model u_fifo (
    .clk_i(clk_i), .push_i(push), .pop_i(pop), .flush_i(fmt_o[7] | fmt_o[6]),
    .wdata_i(wd), .rdata_o(hd), .one_empty_o(f1e), .two_empty_o(f2e),
    .one_full_o(f1f), .two_full_o(f2f));

  always @(posedge clk_i) begin
    for (int k = 0; k < 3; k++) if (starts[k] === 1'b1) scnt[k]++;
  end

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [9:0] idx, input logic [7:0] d,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge clk_i);
    psel <= 1'b1;
    pwr <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge clk_i);
    pen <= 1'b1;
    @(posedge clk_i);
    while (pready !== 1'b1 && n < 50) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 50) error_cnt++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb

  task automatic wreg(input logic [9:0] idx, input logic [7:0] d);
    logic [31:0] v;
    logic e;
    apb(1'b1, idx, d, v, e);
  endtask : wreg

  task automatic rdreg(input logic [9:0] idx, output logic [31:0] v);
    logic e;
    apb(1'b0, idx, 8'h00, v, e);
  endtask : rdreg

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask : cyc

  task automatic pulse(input int i);
    @(posedge clk_i);
    ev <= 4'(1 << i);
    @(posedge clk_i);
    ev <= 4'h0;
    cyc(2);
  endtask : pulse

  // counts card clock edges over 24 cycles; a running clock gives 12
  task automatic runs(output logic r);
    logic last;
    int t;
    int rises;
    int ticks;
    t = 0;
    rises = 0;
    ticks = 0;
    cyc(4);
    last = cclk;
    repeat (24) begin
      @(posedge clk_i);
      if (cclk !== last) t++;
      if (cclk === 1'b1 && last === 1'b0) rises++;
      if (tick === 1'b1) ticks++;
      last = cclk;
    end
    check("card ticks", 32'(ticks), 32'(rises));
    r = (t >= 10) ? 1'b1 : ((t == 0) ? 1'b0 : 1'bx);
  endtask : runs

  initial begin
    #(60000 * 5);
    error_cnt++;
    final_report();
  end

  initial begin
    logic [31:0] v;
    logic [7:0] d;
    logic [7:0] ex;
    logic e, r;
    cyc(8);
    rst_i <= 1'b0;
    check("outputs at reset", 32'({fmt_o, blen, dir, starts, irq}), 32'h0);
    rdreg(CHFIC_IDX_CTL_TRANSFER, v);
    check("transfer reset", v, 32'h0);
    rdreg(CHFIC_IDX_IRQ_MASKS, v);
    check("mask reset", v, 32'(CHFIC_RST_IRQ_MASKS));
    apb(1'b0, 10'h0F0, 8'h00, v, e);
    check("unmapped error", 32'(e), 32'h1);
    for (int i = 0; i < 4; i++) begin
      d = 8'($random(seed));
      wreg(CHFIC_IDX_CTL_FORMAT, d);
      cyc(1);
      check("format pins", 32'(fmt_o), 32'(d));
      d = 8'($random(seed));
      d[7:4] = d[7:4] % 4'd12;
      d[2:0] = 3'b000;
      wreg(CHFIC_IDX_CTL_TRANSFER, d);
      cyc(1);
      check("transfer pins", 32'({blen, dir}), 32'(d[7:3]));
      rdreg(CHFIC_IDX_CTL_TRANSFER, v);
      check("transfer readback", v, 32'(d));
    end
    wreg(CHFIC_IDX_CTL_FORMAT, 8'h00);
    for (int k = 0; k < 3; k++) begin
      scnt = '{0, 0, 0};
      wreg(CHFIC_IDX_CTL_TRANSFER, 8'(1 << k));
      cyc(4);
      check("no start on set", 32'(scnt[k]), 32'h0);
      wreg(CHFIC_IDX_CTL_TRANSFER, 8'h00);
      cyc(5);
      check("one start", 32'(scnt[k]), 32'h1);
      check("all starts", 32'(scnt[0] + scnt[1] + scnt[2]), 32'h1);
    end
    $display("test registers done");
    wreg(CHFIC_IDX_IRQ_MASKS, 8'h0F);
    wreg(CHFIC_IDX_CPU_IEN, 8'h01);
    rdreg(CHFIC_IDX_IRQ_FLAGS, v);
    for (int i = 0; i < 4; i++) begin
      ex = 8'h03 | 8'(8'h10 << i);
      pulse(i);
      check("irq raised", 32'(irq), 32'h1);
      rdreg(CHFIC_IDX_IRQ_FLAGS, v);
      for (int b = 0; b < 8; b++) check("flag bit", 32'(v[b]), 32'(ex[b]));
      cyc(1);
      check("irq after read", 32'(irq), 32'h0);
      wreg(CHFIC_IDX_IRQ_MASKS, 8'h0F | 8'(8'h10 << i));
      pulse(i);
      check("masked irq", 32'(irq), 32'h0);
      rdreg(CHFIC_IDX_IRQ_FLAGS, v);
      check("masked flag kept", v, 32'(ex));
      wreg(CHFIC_IDX_IRQ_MASKS, 8'h0F);
    end
    wreg(CHFIC_IDX_IRQ_MASKS, 8'hFE);
    cyc(1);
    check("fifo empty irq", 32'(irq), 32'h1);
    wreg(CHFIC_IDX_CPU_IEN, 8'h00);
    cyc(1);
    check("global enable off", 32'(irq), 32'h0);
    wreg(CHFIC_IDX_IRQ_MASKS, 8'hFF);
    $display("test interrupts done");
    wreg(CHFIC_IDX_CTL_TIMING, 8'h81);
    wreg(CHFIC_IDX_CTL_TRANSFER, 8'h08);
    runs(r);
    check("tx stopped", 32'(r), 32'h0);
    check("frozen", 32'(frozen), 32'h1);
    for (int i = 0; i < 16; i++) begin
      d = 8'($random(seed));
      expq.push_back(d);
      wreg(CHFIC_IDX_DATA_PORT, d);
      if (i == 0) begin
        runs(r);
        check("tx restarted", 32'(r), 32'h1);
        check("thawed", 32'(frozen), 32'h0);
      end
    end
    runs(r);
    check("tx full runs", 32'(r), 32'h1);
    wreg(CHFIC_IDX_CTL_TRANSFER, 8'h00);
    runs(r);
    check("rx stopped", 32'(r), 32'h0);
    for (int i = 0; i < 16; i++) begin
      rdreg(CHFIC_IDX_DATA_PORT, v);
      check("data byte", v, 32'(expq.pop_front()));
      if (i == 0) begin
        runs(r);
        check("rx restarted", 32'(r), 32'h1);
      end
    end
    runs(r);
    check("rx empty runs", 32'(r), 32'h1);
    wreg(CHFIC_IDX_CTL_TIMING, 8'h80);
    wreg(CHFIC_IDX_CTL_TRANSFER, 8'h08);
    runs(r);
    check("no flow control runs", 32'(r), 32'h1);
    $display("test flow control done");
    wreg(CHFIC_IDX_CTL_TRANSFER, 8'hB8);
    rst_i <= 1'b1;
    cyc(2);
    rst_i <= 1'b0;
    check("outputs after reset", 32'({fmt_o, blen, dir, starts, irq, frozen}), 32'h1);
    rdreg(CHFIC_IDX_CTL_TRANSFER, v);
    check("transfer after reset", v, 32'h0);
    $display("test reset done");
    final_report();
  end
endmodule : test_chfic_top
